// ---- core/isfs_defs.vh ----
// Constants for the isolated supply fault sequencer.
`ifndef ISFS_DEFS_VH
`define ISFS_DEFS_VH

`define ISFS_CLK_HZ            40000000
`define ISFS_SS_TIMEOUT_US     28400
`define ISFS_SS_TIMEOUT_CYC    ((`ISFS_SS_TIMEOUT_US * (`ISFS_CLK_HZ / 1000000)))
`define ISFS_SS_STEP_US        128
`define ISFS_SS_STEP_CYC       (`ISFS_SS_STEP_US * (`ISFS_CLK_HZ / 1000000))
`define ISFS_SS_STEPS          3'h7
`define ISFS_DUTY_W            3
`define ISFS_DUTY_START        3'h1
`define ISFS_DUTY_FULL         3'h4
`define ISFS_REF_W             3
`define ISFS_REF_FULL          3'h7

`define ISFS_ST_DISABLE        3'h0
`define ISFS_ST_SOFTSTART      3'h1
`define ISFS_ST_NORMAL         3'h2
`define ISFS_ST_AUTO_PROT      3'h3
`define ISFS_ST_LATCHED        3'h4

`define ISFS_CAUSE_W           3
`define ISFS_CAUSE_UV          0
`define ISFS_CAUSE_OV          1
`define ISFS_CAUSE_OT          2

`endif

// ---- core/isfs_sequencer.v ----
// Mode controller and protection latch for an isolated supply module.
//
// Functional notes
// - Input overvoltage stops switching at once; no energy goes across.
// - After input overvoltage recovers, soft start if enabled, else stay disabled.
// - Input overvoltage entry or exit never clears a latched protection.
// - Feedback undervoltage on either rail halts switching and releases power good.
// - Undervoltage masked during soft start; checked again when soft start completes.
// - Undervoltage latches off; only supply cycle or enable toggle clears it.
// - Feedback overvoltage, set ten percent above target, stops switching immediately.
// - Fail-safe rail overvoltage above 31 V shuts down immediately.
// - Both overvoltage trips enter the latched-off protection state.
// - Overload is caught as undervoltage from output sag, then latched off.
// - Either thermal trip stops switching, releases power good and latches off.
// - Thermal latch clears only when cool, then supply cycle or enable toggle.
// - Disable mode keeps outputs off and waits for enable high.
// - Soft start raises references gradually; burst duty steps up until bias is ok, then goes full.
// - After input fault clears: disable if enable low, else soft start to normal.
// - Latched state holds after fault clears until supply reset or enable toggle.
// - Undriven enable reads low; the host should drive it.
// - Power good low and regulating only when input valid, enabled, fault free.
// - Soft start ends after 8 steps of 128 us, before the 28.4 ms no-bias timeout can latch off.
`timescale 1ns/10ps
`include "isfs_defs.vh"

module isfs_sequencer #(
    parameter SS_TIMEOUT_CYC = `ISFS_SS_TIMEOUT_CYC,
    parameter SS_STEP_CYC    = `ISFS_SS_STEP_CYC
) (
    input  wire                     i_sys_clk,
    input  wire                     i_rstn,
    input  wire                     i_converter_enable_in,
    input  wire                     i_input_uvlo,
    input  wire                     i_input_analog_uvlo,
    input  wire                     i_input_over_lockout,
    input  wire                     i_high_rail_uv_fall,
    input  wire                     i_high_rail_uv_rise_ok,
    input  wire                     i_low_rail_uv_fall,
    input  wire                     i_low_rail_uv_rise_ok,
    input  wire                     i_high_rail_ov,
    input  wire                     i_low_rail_ov,
    input  wire                     i_failsafe_over_threshold,
    input  wire                     i_bias_ok,
    input  wire                     i_primary_thermal_trip,
    input  wire                     i_secondary_thermal_trip,
    output reg                      o_switch_en,
    output reg                      o_power_good_n_oe,
    output reg                      o_power_good_n_out,
    output reg  [`ISFS_DUTY_W-1:0]  o_burst_duty,
    output reg  [`ISFS_REF_W-1:0]   o_ref_step,
    output reg  [2:0]               o_mode,
    output reg  [`ISFS_CAUSE_W-1:0] o_latch_cause
);

    localparam NSYNC = 13;
    localparam [2:0] ST_DISABLE   = `ISFS_ST_DISABLE;
    localparam [2:0] ST_SOFTSTART = `ISFS_ST_SOFTSTART;
    localparam [2:0] ST_NORMAL    = `ISFS_ST_NORMAL;
    localparam [2:0] ST_AUTO_PROT = `ISFS_ST_AUTO_PROT;
    localparam [2:0] ST_LATCHED   = `ISFS_ST_LATCHED;
    localparam [20:0] SS_TO       = SS_TIMEOUT_CYC[20:0];
    localparam [12:0] STEP_CYC    = SS_STEP_CYC[12:0];
    localparam [2:0] REF_LAST     = `ISFS_SS_STEPS;

    wire [NSYNC-1:0] raw_in;
    reg  [NSYNC-1:0] meta_q;
    reg  [NSYNC-1:0] sync_q;

    // Enable sits in the top bit and the two thermal trips in the lowest two bits.
    assign raw_in = {i_converter_enable_in, i_input_uvlo, i_input_analog_uvlo, i_input_over_lockout,
                     i_high_rail_uv_fall, i_high_rail_uv_rise_ok, i_low_rail_uv_fall, i_low_rail_uv_rise_ok,
                     i_high_rail_ov, i_low_rail_ov, i_failsafe_over_threshold,
                     i_primary_thermal_trip, i_secondary_thermal_trip};

    // The pin is assumed to resolve an open enable to low before reaching here.
    genvar g;
    generate
        for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
            always @(posedge i_sys_clk) begin
                if (!i_rstn) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= raw_in[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    // Bias threshold is used only as a level inside soft start; synchronized separately.
    reg bias_meta_q;
    reg bias_q;

    wire ena       = sync_q[12];
    wire uvlo      = sync_q[11];
    wire ana_uvlo  = sync_q[10];
    wire input_over_lockout      = sync_q[9];
    wire uv_now    = sync_q[8] | sync_q[6];
    wire uv_ok     = sync_q[7] & sync_q[5];
    wire ov_fb     = sync_q[4] | sync_q[3];
    wire ov_fs     = sync_q[2];
    wire ot_now    = sync_q[1] | sync_q[0];
    wire input_bad = uvlo | input_over_lockout;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg         ena_q;
    reg         ena_low_seen_q;
    // Cause bits remember which latched fault is pending across auto protection.
    reg  [2:0]  cause_q;
    reg  [2:0]  cause_d;
    // Wide enough to hold the full default soft-start timeout.
    reg  [20:0] ss_cnt_q;
    reg  [12:0] step_cnt_q;
    reg  [2:0]  ref_q;
    reg  [2:0]  duty_q;

    function is_running;
        input [2:0] st;
        begin
            is_running = (st == ST_SOFTSTART) || (st == ST_NORMAL);
        end
    endfunction

    wire ss_done     = (ref_q == REF_LAST) && (step_cnt_q == STEP_CYC - 13'h0001);
    // The timeout is measured from soft-start entry, not from the loss of bias.
    wire ss_timeout  = (ss_cnt_q == SS_TO - 21'h00_0001) && !bias_q;
    wire ena_rise    = ena & ~ena_q;
    // A latch is released by the analog supply reset or a low-then-high enable toggle.
    wire latch_clear = ana_uvlo | (ena_rise & ena_low_seen_q);
    // A thermal latch may not clear while either stage is still hot.
    wire ot_block    = cause_q[`ISFS_CAUSE_OT] & ot_now;

    always @* begin
        state_d = state_q;
        cause_d = cause_q;
        case (state_q)
            ST_DISABLE: begin
                // Outputs stay off here; only enable starts a soft start.
                if (input_bad) begin
                    state_d = ST_AUTO_PROT;
                end else if (ena) begin
                    state_d = ST_SOFTSTART;
                end
            end
            ST_SOFTSTART, ST_NORMAL: begin
                // Input lockout outranks the latched faults and records no cause.
                if (input_bad) begin
                    state_d = ST_AUTO_PROT;
                end else if (ot_now) begin
                    state_d = ST_LATCHED;
                    cause_d[`ISFS_CAUSE_OT] = 1'b1;
                end else if (ov_fb | ov_fs) begin
                    state_d = ST_LATCHED;
                    cause_d[`ISFS_CAUSE_OV] = 1'b1;
                end else if (state_q == ST_NORMAL && uv_now) begin
                    state_d = ST_LATCHED;
                    cause_d[`ISFS_CAUSE_UV] = 1'b1;
                end else if (state_q == ST_SOFTSTART && ss_timeout) begin
                    state_d = ST_LATCHED;
                    cause_d[`ISFS_CAUSE_UV] = 1'b1;
                end else if (state_q == ST_SOFTSTART && ss_done) begin
                    if (uv_ok) begin
                        state_d = ST_NORMAL;
                    end else begin
                        state_d = ST_LATCHED;
                        cause_d[`ISFS_CAUSE_UV] = 1'b1;
                    end
                end else if (!ena) begin
                    state_d = ST_DISABLE;
                end
            end
            ST_AUTO_PROT: begin
                // A remembered cause sends the machine back to latched once the input recovers.
                if (ana_uvlo && !ot_block) begin
                    cause_d = 3'h0;
                end
                if (!input_bad) begin
                    if (cause_d != 3'h0) begin
                        state_d = ST_LATCHED;
                    end else if (ena) begin
                        state_d = ST_SOFTSTART;
                    end else begin
                        state_d = ST_DISABLE;
                    end
                end
            end
            ST_LATCHED: begin
                // Input overvoltage only parks the machine; the cause is kept.
                if (latch_clear && !ot_block) begin
                    cause_d = 3'h0;
                    if (input_bad) begin
                        state_d = ST_AUTO_PROT;
                    end else if (ena) begin
                        state_d = ST_SOFTSTART;
                    end else begin
                        state_d = ST_DISABLE;
                    end
                end else if (input_over_lockout) begin
                    state_d = ST_AUTO_PROT;
                end
            end
            default: begin
                state_d = ST_DISABLE;
            end
        endcase
    end

    // A fresh soft start shows its first duty and reference step on the entry edge.
    wire       ss_entry = (state_d == ST_SOFTSTART) && (state_q != ST_SOFTSTART);
    reg  [2:0] duty_out_d;
    reg  [2:0] ref_out_d;

    always @* begin
        duty_out_d = 3'h0;
        ref_out_d  = 3'h0;
        if (ss_entry) begin
            duty_out_d = `ISFS_DUTY_START;
            ref_out_d  = 3'h0;
        end else if (state_d == ST_NORMAL) begin
            duty_out_d = duty_q;
            ref_out_d  = REF_LAST;
        end else if (state_d == ST_SOFTSTART) begin
            duty_out_d = duty_q;
            ref_out_d  = ref_q;
        end
    end

    // The timeout counter stops at its last count, so a long soft start cannot wrap it.
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            ss_cnt_q   <= 21'h00_0000;
            step_cnt_q <= 13'h0000;
            ref_q      <= 3'h0;
            duty_q     <= 3'h0;
        end else if (ss_entry) begin
            ss_cnt_q   <= 21'h00_0000;
            step_cnt_q <= 13'h0000;
            ref_q      <= 3'h0;
            duty_q     <= `ISFS_DUTY_START;
        end else if (state_q == ST_SOFTSTART) begin
            if (ss_cnt_q != SS_TO - 21'h00_0001) begin
                ss_cnt_q <= ss_cnt_q + 21'h00_0001;
            end
            if (step_cnt_q == STEP_CYC - 13'h0001) begin
                step_cnt_q <= 13'h0000;
                if (ref_q != REF_LAST) begin
                    ref_q <= ref_q + 3'h1;
                end
                if (!bias_q && duty_q != `ISFS_DUTY_FULL) begin
                    duty_q <= duty_q + 3'h1;
                end
            end else begin
                step_cnt_q <= step_cnt_q + 13'h0001;
            end
            if (bias_q) begin
                duty_q <= `ISFS_DUTY_FULL;
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            bias_meta_q        <= 1'b0;
            bias_q             <= 1'b0;
            state_q            <= ST_DISABLE;
            cause_q            <= 3'h0;
            ena_q              <= 1'b0;
            ena_low_seen_q     <= 1'b0;
            o_switch_en        <= 1'b0;
            o_power_good_n_oe  <= 1'b0;
            o_power_good_n_out <= 1'b0;
            o_burst_duty       <= 3'h0;
            o_ref_step         <= 3'h0;
            o_mode             <= ST_DISABLE;
            o_latch_cause      <= 3'h0;
        end else begin
            bias_meta_q <= i_bias_ok;
            bias_q      <= bias_meta_q;
            state_q     <= state_d;
            cause_q     <= cause_d;
            ena_q       <= ena;
            if (state_q == ST_LATCHED) begin
                // Only a low seen while latched counts toward the clearing toggle.
                ena_low_seen_q <= ena_low_seen_q | ~ena;
            end else begin
                ena_low_seen_q <= 1'b0;
            end
            o_switch_en        <= is_running(state_d);
            o_power_good_n_oe  <= (state_d == ST_NORMAL);
            o_power_good_n_out <= 1'b0;
            o_burst_duty       <= duty_out_d;
            o_ref_step         <= ref_out_d;
            o_mode             <= state_d;
            o_latch_cause      <= cause_d;
        end
    end

endmodule // isfs_sequencer

// ---- verif/isfs_sequencer_sva.sv ----
// Checker on the fault sequencer ports.
`timescale 1ns/10ps
`include "isfs_defs.vh"
module isfs_sequencer_sva #(
    parameter SS_TIMEOUT_CYC = 40,
    parameter SS_STEP_CYC    = 8
) (
    input wire logic       i_sys_clk,
    input wire logic       i_rstn,
    input wire logic       i_converter_enable_in,
    input wire logic       i_input_uvlo,
    input wire logic       i_input_analog_uvlo,
    input wire logic       i_input_over_lockout,
    input wire logic       i_high_rail_uv_fall,
    input wire logic       i_low_rail_uv_fall,
    input wire logic       i_high_rail_ov,
    input wire logic       i_low_rail_ov,
    input wire logic       i_failsafe_over_threshold,
    input wire logic       i_bias_ok,
    input wire logic       i_primary_thermal_trip,
    input wire logic       i_secondary_thermal_trip,
    input wire logic       o_switch_en,
    input wire logic       o_power_good_n_oe,
    input wire logic [2:0] o_burst_duty,
    input wire logic [2:0] o_mode,
    input wire logic [2:0] o_latch_cause
);
    localparam int SS_MAX = 8 * SS_STEP_CYC + 4;
    wire         vin_ok = !i_input_uvlo && !i_input_analog_uvlo && !i_input_over_lockout;
    wire         ok_in  = vin_ok && i_converter_enable_in;
    wire         ovf    = i_high_rail_ov || i_low_rail_ov || i_failsafe_over_threshold;
    wire         otf    = i_primary_thermal_trip || i_secondary_thermal_trip;
    logic [15:0] bias_wait_q;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    always @(posedge i_sys_clk) begin
        if (!i_rstn || o_mode != `ISFS_ST_SOFTSTART || i_bias_ok) bias_wait_q <= 16'h0000;
        else bias_wait_q <= bias_wait_q + 16'h0001;
    end
    input_over_lockout_stop_a: assert property (i_input_over_lockout [*3] |=> !o_switch_en && !o_power_good_n_oe)
        else $error("switching during input overvoltage");
    pg_mode_a: assert property (o_power_good_n_oe == (o_mode == `ISFS_ST_NORMAL) && (!o_power_good_n_oe || o_switch_en))
        else $error("power good outside normal mode");
    uv_trip_a: assert property ((i_high_rail_uv_fall || i_low_rail_uv_fall) [*3] |=> o_mode != `ISFS_ST_NORMAL)
        else $error("normal mode kept under undervoltage");
    ov_latch_a: assert property ((ok_in && ovf && o_mode == `ISFS_ST_NORMAL) [*3]
        |=> o_mode == `ISFS_ST_LATCHED && o_latch_cause[`ISFS_CAUSE_OV]) else $error("overvoltage did not latch");
    ot_latch_a: assert property ((ok_in && otf && o_mode == `ISFS_ST_NORMAL) [*3]
        |=> o_mode == `ISFS_ST_LATCHED && o_latch_cause[`ISFS_CAUSE_OT]) else $error("thermal trip did not latch");
    latch_hold_a: assert property ((ok_in && o_mode == `ISFS_ST_LATCHED) [*5] |=> o_mode == `ISFS_ST_LATCHED)
        else $error("latched state left without reset");
    ss_bound_a: assert property ($rose(o_mode == `ISFS_ST_SOFTSTART) |-> ##[1:SS_MAX] o_mode != `ISFS_ST_SOFTSTART)
        else $error("soft start did not complete");
    bias_wait_a: assert property (bias_wait_q <= SS_TIMEOUT_CYC + 4)
        else $error("soft start timeout missed");
    ss_ramp_a: assert property ($rose(o_mode == `ISFS_ST_SOFTSTART) |-> o_switch_en && o_burst_duty == `ISFS_DUTY_START)
        else $error("soft start did not begin at lowest duty");
    sync_delay_a: assert property (vin_ok && o_mode == `ISFS_ST_DISABLE && $rose(i_converter_enable_in)
        |-> ##1 (o_mode == `ISFS_ST_DISABLE) [*2] ##1 o_mode == `ISFS_ST_SOFTSTART) else $error("enable latency wrong");
endmodule // isfs_sequencer_sva

// ---- verif/isfs_host.sv ----
// Host model driving enable and reading the power-good pin.
`timescale 1ns/10ps
module isfs_host #(
    parameter LOW_MIN = 6001
) (
    input  wire logic i_sys_clk,
    input  wire logic i_want_en,
    input  wire logic i_float,
    input  wire logic i_pg_oe,
    output wire logic o_en,
    output wire logic o_pg_n
);
    logic en_q  = 1'b0;
    int   low_q = LOW_MIN;
    always @(negedge i_sys_clk) begin
        en_q  <= i_want_en && (en_q || low_q >= LOW_MIN);
        low_q <= en_q ? 0 : (low_q >= LOW_MIN ? LOW_MIN : low_q + 1);
    end
    assign o_en   = i_float ? 1'b0 : en_q;
    assign o_pg_n = i_pg_oe ? 1'b0 : 1'b1;
endmodule // isfs_host

// ---- verif/isfs_sequencer_tb.sv ----
// Self-checking bench for the fault sequencer.
`timescale 1ns/10ps
`include "isfs_defs.vh"
module isfs_sequencer_tb;
    logic       clk  = 1'b0;
    logic       rstn = 1'b0;
    logic       want = 1'b0;
    logic       flt  = 1'b1;
    logic       uvlo = 1'b0;
    logic       auv  = 1'b0;
    logic       ovl  = 1'b0;
    logic       hok  = 1'b1;
    logic       lok  = 1'b1;
    logic       bias = 1'b1;
    logic [6:0] fv   = 7'h00;
    logic       en, sw, oe, pgn;
    logic [2:0] mode, cause;
    logic       pgo;
    logic [2:0] duty, refs;
    int         mismatches  = 0;
    int         checks_done = 0;
    int         cyc_n       = 0;
    int         i;
    isfs_host host_u (.i_sys_clk(clk), .i_want_en(want), .i_float(flt), .i_pg_oe(oe), .o_en(en), .o_pg_n(pgn));
    isfs_sequencer #(.SS_TIMEOUT_CYC(40), .SS_STEP_CYC(8)) dut_u (
        .i_sys_clk(clk), .i_rstn(rstn), .i_converter_enable_in(en), .i_input_uvlo(uvlo),
        .i_input_analog_uvlo(auv), .i_input_over_lockout(ovl), .i_high_rail_uv_fall(fv[0]),
        .i_high_rail_uv_rise_ok(hok), .i_low_rail_uv_fall(fv[1]), .i_low_rail_uv_rise_ok(lok),
        .i_high_rail_ov(fv[2]), .i_low_rail_ov(fv[3]), .i_failsafe_over_threshold(fv[4]), .i_bias_ok(bias),
        .i_primary_thermal_trip(fv[5]), .i_secondary_thermal_trip(fv[6]), .o_switch_en(sw),
        .o_power_good_n_oe(oe), .o_power_good_n_out(pgo), .o_burst_duty(duty), .o_ref_step(refs), .o_mode(mode),
        .o_latch_cause(cause));
    function automatic logic [2:0] cause_of(input int k);
        return k < 2 ? 3'h1 << `ISFS_CAUSE_UV : (k < 5 ? 3'h1 << `ISFS_CAUSE_OV : 3'h1 << `ISFS_CAUSE_OT);
    endfunction
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reach(input logic [2:0] m, input int lim);
        for (int k = 0; k < lim && mode !== m; k++) @(negedge clk);
        chk(mode, m);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 50000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'h7878_144e));
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        want = 1'b1;
        repeat (10) @(negedge clk);
        chk(mode, `ISFS_ST_DISABLE);
        chk({2'b00, pgn}, 3'h1);
        flt = 1'b0;
        repeat (20) @(negedge clk);
        fv[1] = 1'b1;
        lok = 1'b0;
        repeat (20) @(negedge clk);
        chk(mode, `ISFS_ST_SOFTSTART);
        fv[1] = 1'b0;
        lok = 1'b1;
        reach(`ISFS_ST_NORMAL, 100);
        chk({2'b00, pgn}, 3'h0);
        chk({2'b00, pgo}, 3'h0);
        chk(refs, `ISFS_REF_FULL);
        chk(duty, `ISFS_DUTY_FULL);
        for (i = 0; i < 7; i++) begin
            repeat ($urandom_range(40, 5)) @(negedge clk);
            fv[i] = 1'b1;
            hok = (i != 0);
            lok = (i != 1);
            reach(`ISFS_ST_LATCHED, 10);
            chk(cause & cause_of(i), cause_of(i));
            chk({2'b00, pgn}, 3'h1);
            fv = 7'h00;
            hok = 1'b1;
            lok = 1'b1;
            if (i == 2) begin
                ovl = 1'b1;
                reach(`ISFS_ST_AUTO_PROT, 10);
                ovl = 1'b0;
            end
            repeat (10) @(negedge clk);
            chk(mode, `ISFS_ST_LATCHED);
            if (i[0]) begin
                auv = 1'b1;
                uvlo = 1'b1;
                reach(`ISFS_ST_AUTO_PROT, 10);
                auv = 1'b0;
                uvlo = 1'b0;
                reach(`ISFS_ST_NORMAL, 200);
            end else begin
                want = 1'b0;
                repeat (10) @(negedge clk);
                chk(mode, `ISFS_ST_LATCHED);
                want = 1'b1;
                reach(`ISFS_ST_NORMAL, 6200);
            end
        end
        ovl = 1'b1;
        reach(`ISFS_ST_AUTO_PROT, 10);
        chk({2'b00, sw}, 3'h0);
        chk(duty, 3'h0);
        ovl = 1'b0;
        reach(`ISFS_ST_NORMAL, 200);
        ovl = 1'b1;
        want = 1'b0;
        reach(`ISFS_ST_AUTO_PROT, 10);
        ovl = 1'b0;
        reach(`ISFS_ST_DISABLE, 10);
        hok = 1'b0;
        want = 1'b1;
        reach(`ISFS_ST_LATCHED, 6200);
        auv = 1'b1;
        uvlo = 1'b1;
        reach(`ISFS_ST_AUTO_PROT, 10);
        hok = 1'b1;
        bias = 1'b0;
        auv = 1'b0;
        uvlo = 1'b0;
        reach(`ISFS_ST_SOFTSTART, 10);
        chk(duty, `ISFS_DUTY_START);
        chk(refs, 3'h0);
        reach(`ISFS_ST_LATCHED, 100);
        tally_and_finish();
    end
endmodule // isfs_sequencer_tb
bind isfs_sequencer isfs_sequencer_sva #(.SS_TIMEOUT_CYC(SS_TIMEOUT_CYC), .SS_STEP_CYC(SS_STEP_CYC)) sva_u (.*);
